// file: include/pcise_map.svh
/*
  Register offsets, field positions and reset values of the single-cycle PCI
  initiator engine. Assumes a 24-bit register-space byte address.
*/
`ifndef PCISE_MAP_SVH
`define PCISE_MAP_SVH

`define PCISE_OFS_STATUS 24'h10_3004
`define PCISE_OFS_CONTROL 24'h10_3008
`define PCISE_OFS_CACHE_ADR 24'h10_300c
`define PCISE_OFS_CACHE_DATA 24'h10_3010
`define PCISE_OFS_CFG_ADR 24'h10_3014
`define PCISE_OFS_CFG_DATA 24'h10_3018
`define PCISE_OFS_CFG_CTL 24'h10_301c
`define PCISE_OFS_IO_ADR 24'h10_3020
`define PCISE_OFS_IO_DATA 24'h10_3024
`define PCISE_OFS_IO_CYCLE_CONTROL 24'h10_3028

// Status bits
`define PCISE_ST_CFG_BUSY 0
`define PCISE_ST_CFG_DONE 1
`define PCISE_ST_IO_BUSY 2
`define PCISE_ST_IO_DONE 3
`define PCISE_ST_MASTER_ABORT 4
`define PCISE_ST_OVERLAP 8

// Control bits
`define PCISE_CT_IE_CFG 2
`define PCISE_CT_IE_IO 3
`define PCISE_CT_IE_OVERLAP 6

// Cycle control and address fields
`define PCISE_CC_RW 4
`define PCISE_CC_BE_MSB 3
`define PCISE_CA_DN_LSB 11
`define PCISE_CA_BUS_MSB 1

// Reset values
`define PCISE_RST_WORD 32'h0000_0000
`define PCISE_RST_CTL 5'h1f

`endif

// file: include/pcise_pkg.sv
/*
  Types of the single-cycle PCI initiator engine: sequencer states, request
  sources and bus command encodings. No assumptions.
*/
package pcise_pkg;

  typedef enum logic [1:0] {
    pcise_idle = 2'b00,
    pcise_bus = 2'b01
  } pcise_state_type;

  typedef enum logic [1:0] {
    pcise_src_cache = 2'b00,
    pcise_src_cfg = 2'b01,
    pcise_src_io = 2'b10
  } pcise_src_type;

  typedef enum logic [3:0] {
    pcise_cmd_io_rd = 4'h2,
    pcise_cmd_io_wr = 4'h3,
    pcise_cmd_mem_rd = 4'h6,
    pcise_cmd_mem_wr = 4'h7,
    pcise_cmd_cfg_rd = 4'ha,
    pcise_cmd_cfg_wr = 4'hb
  } pcise_cmd_type;

endpackage : pcise_pkg

// file: rtl/pcise_cycle_slot.sv
/*
  One software-driven cycle slot (configuration or I/O): address, data and
  control registers with busy and done flags. Assumes the parent accepts a
  control write only while no slot is busy and pulses finish once per cycle.
*/
`timescale 1ns/100ps
`include "pcise_map.svh"

module pcise_cycle_slot (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Register writes
  input wire logic [31:0] wdata_i,
  input wire logic wr_adr_i,
  input wire logic wr_data_i,
  input wire logic launch_i,
  input wire logic clr_done_i,
  // Completion
  input wire logic finish_i,
  input wire logic [31:0] rdata_i,
  // State
  output logic [31:0] adr_o,
  output logic [31:0] data_o,
  output logic [4:0] ctl_o,
  output logic busy_o,
  output logic done_o
);

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      adr_o <= `PCISE_RST_WORD;
    end else if (wr_adr_i) begin
      adr_o <= wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ctl_o <= `PCISE_RST_CTL;
    end else if (launch_i) begin
      ctl_o <= wdata_i[4:0];
    end
  end

  // Returned data wins over a stray software write
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      data_o <= `PCISE_RST_WORD;
    end else if (finish_i && ctl_o[`PCISE_CC_RW]) begin
      data_o <= rdata_i;
    end else if (wr_data_i) begin
      data_o <= wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      busy_o <= 1'b0;
    end else if (launch_i) begin
      busy_o <= 1'b1;
    end else if (finish_i) begin
      busy_o <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      done_o <= 1'b0;
    end else if (finish_i) begin
      done_o <= 1'b1;
    end else if (clr_done_i) begin
      done_o <= 1'b0;
    end
  end

endmodule : pcise_cycle_slot

// file: rtl/pcise_cache_path.sv
/*
  Data-cache path: 30-bit word address and data registers, load tracking and
  the completion pulse back to the cache. Assumes the cache holds its read
  request level until ready, and the parent grants one request at a time.
*/
`timescale 1ns/100ps
`include "pcise_map.svh"

module pcise_cache_path (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Data cache side
  input wire logic dc_adr_wr_i,
  input wire logic [29:0] dc_adr_i,
  input wire logic dc_data_wr_i,
  input wire logic [31:0] dc_data_i,
  input wire logic dc_read_op_i,
  // Local register write of the address
  input wire logic mmio_adr_wr_i,
  input wire logic [29:0] mmio_adr_i,
  // Sequencer side
  input wire logic grant_i,
  input wire logic finish_i,
  input wire logic abort_i,
  input wire logic [31:0] rdata_i,
  output logic req_o,
  output logic rd_o,
  output logic [29:0] adr_o,
  output logic [31:0] data_o,
  output logic ready_o
);

  logic adr_loaded;
  logic data_loaded;
  logic in_flight;

  assign req_o = adr_loaded && (dc_read_op_i || data_loaded) && !in_flight;

  // local-only address; a cache address write in the same cycle wins over a software write
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      adr_o <= 30'h0000_0000;
    end else if (dc_adr_wr_i) begin
      adr_o <= dc_adr_i;
    end else if (mmio_adr_wr_i) begin
      adr_o <= mmio_adr_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      adr_loaded <= 1'b0;
      data_loaded <= 1'b0;
    end else if (grant_i) begin
      adr_loaded <= 1'b0;
      data_loaded <= 1'b0;
    end else begin
      adr_loaded <= adr_loaded | dc_adr_wr_i;
      data_loaded <= data_loaded | dc_data_wr_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      in_flight <= 1'b0;
      rd_o <= 1'b0;
    end else if (grant_i) begin
      in_flight <= 1'b1;
      rd_o <= dc_read_op_i;
    end else if (finish_i) begin
      in_flight <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      data_o <= `PCISE_RST_WORD;
    end else if (finish_i && (rd_o || abort_i)) begin
      data_o <= abort_i ? `PCISE_RST_WORD : rdata_i;
    end else if (dc_data_wr_i) begin
      data_o <= dc_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= finish_i;
    end
  end

endmodule : pcise_cache_path

// file: rtl/pcise_engine.sv
/*
  Single-data-phase PCI initiator engine: register port, sequencer that
  issues cache, configuration and I/O cycles to a PCI master, status and
  interrupt. Assumes the master answers each request with one done pulse.
*/
`timescale 1ns/100ps
`include "pcise_map.svh"

module pcise_engine (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic mmio_wr_i,
  input wire logic mmio_rd_i,
  input wire logic mmio_ext_i,
  input wire logic [23:0] mmio_addr_i,
  input wire logic [31:0] mmio_wdata_i,
  output logic [31:0] mmio_rdata_o,
  // Data cache
  input wire logic dc_adr_wr_i,
  input wire logic [29:0] dc_adr_i,
  input wire logic dc_data_wr_i,
  input wire logic [31:0] dc_data_i,
  input wire logic dc_read_op_i,
  output logic dc_ready_o,
  output logic [31:0] dc_data_o,
  // PCI master request
  output logic pci_req_o,
  output logic [3:0] pci_cmd_o,
  output logic [31:0] pci_addr_o,
  output logic [3:0] pci_be_n_o,
  output logic [31:0] pci_wdata_o,
  output logic [20:0] pci_idsel_o,
  input wire logic pci_done_i,
  input wire logic pci_abort_i,
  input wire logic [31:0] pci_rdata_i,
  // Processor interrupt
  output logic cpu_irq_o
);

  function automatic logic reg_hit(input logic [23:0] a, input logic [23:0] ofs);
    return a == ofs;
  endfunction : reg_hit

  pcise_pkg::pcise_state_type state;
  pcise_pkg::pcise_src_type src;
  logic [2:0] irq_en;
  logic master_abort_flag, overlap_flag;
  logic cache_req, cache_rd;
  logic [29:0] cache_adr;
  logic [31:0] cfg_adr, cfg_data, io_adr, io_data;
  logic [4:0] cfg_ctl, io_cycle_control;
  logic cfg_busy, cfg_done, io_busy, io_done;
  logic w_status, w_cfg_ctl, w_io_cycle_control, cfg_launch, io_launch, overlap_evt;
  logic grant_cache, grant_cfg, grant_io, finish;
  logic [1:0] bus_select;
  logic [3:0] next_cmd, next_be;
  logic [31:0] next_addr, next_wdata, rd_word;
  logic [20:0] next_idsel;

  assign w_status = mmio_wr_i && reg_hit(mmio_addr_i, `PCISE_OFS_STATUS);
  assign w_cfg_ctl = mmio_wr_i && reg_hit(mmio_addr_i, `PCISE_OFS_CFG_CTL);
  assign w_io_cycle_control = mmio_wr_i && reg_hit(mmio_addr_i, `PCISE_OFS_IO_CYCLE_CONTROL);
  assign overlap_evt = (w_cfg_ctl || w_io_cycle_control) && (cfg_busy || io_busy);
  assign cfg_launch = w_cfg_ctl && !cfg_busy && !io_busy;
  assign io_launch = w_io_cycle_control && !cfg_busy && !io_busy;

  // Cache path has priority: the processor is stalled on it
  assign grant_cache = (state == pcise_pkg::pcise_idle) && cache_req;
  assign grant_cfg = (state == pcise_pkg::pcise_idle) && !cache_req && cfg_busy;
  assign grant_io = (state == pcise_pkg::pcise_idle) && !cache_req && !cfg_busy && io_busy;
  assign finish = (state == pcise_pkg::pcise_bus) && pci_done_i;
  assign bus_select = cfg_adr[`PCISE_CA_BUS_MSB:0];

  pcise_cache_path u_cache (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .dc_adr_wr_i(dc_adr_wr_i),
    .dc_adr_i(dc_adr_i),
    .dc_data_wr_i(dc_data_wr_i),
    .dc_data_i(dc_data_i),
    .dc_read_op_i(dc_read_op_i),
    .mmio_adr_wr_i(mmio_wr_i && !mmio_ext_i && reg_hit(mmio_addr_i, `PCISE_OFS_CACHE_ADR)),
    .mmio_adr_i(mmio_wdata_i[31:2]),
    .grant_i(grant_cache),
    .finish_i(finish && (src == pcise_pkg::pcise_src_cache)),
    .abort_i(pci_abort_i),
    .rdata_i(pci_rdata_i),
    .req_o(cache_req),
    .rd_o(cache_rd),
    .adr_o(cache_adr),
    .data_o(dc_data_o),
    .ready_o(dc_ready_o)
  );

  pcise_cycle_slot u_cfg (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .wdata_i(mmio_wdata_i),
    .wr_adr_i(mmio_wr_i && reg_hit(mmio_addr_i, `PCISE_OFS_CFG_ADR)),
    .wr_data_i(mmio_wr_i && reg_hit(mmio_addr_i, `PCISE_OFS_CFG_DATA)),
    .launch_i(cfg_launch),
    .clr_done_i(w_status && mmio_wdata_i[`PCISE_ST_CFG_DONE]),
    .finish_i(finish && (src == pcise_pkg::pcise_src_cfg)),
    .rdata_i(pci_rdata_i),
    .adr_o(cfg_adr),
    .data_o(cfg_data),
    .ctl_o(cfg_ctl),
    .busy_o(cfg_busy),
    .done_o(cfg_done)
  );

  pcise_cycle_slot u_io (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .wdata_i(mmio_wdata_i),
    .wr_adr_i(mmio_wr_i && reg_hit(mmio_addr_i, `PCISE_OFS_IO_ADR)),
    .wr_data_i(mmio_wr_i && reg_hit(mmio_addr_i, `PCISE_OFS_IO_DATA)),
    .launch_i(io_launch),
    .clr_done_i(w_status && mmio_wdata_i[`PCISE_ST_IO_DONE]),
    .finish_i(finish && (src == pcise_pkg::pcise_src_io)),
    .rdata_i(pci_rdata_i),
    .adr_o(io_adr),
    .data_o(io_data),
    .ctl_o(io_cycle_control),
    .busy_o(io_busy),
    .done_o(io_done)
  );

  // Bus request contents for the winning source
  always_comb begin
    next_cmd = cache_rd ? pcise_pkg::pcise_cmd_mem_rd : pcise_pkg::pcise_cmd_mem_wr;
    next_addr = {cache_adr, 2'b00};
    next_be = 4'h0;
    next_wdata = dc_data_o;
    next_idsel = 21'h00_0000;
    if (grant_cache) begin
      next_cmd = dc_read_op_i ? pcise_pkg::pcise_cmd_mem_rd : pcise_pkg::pcise_cmd_mem_wr;
    end else if (grant_cfg) begin
      next_cmd = cfg_ctl[`PCISE_CC_RW] ? pcise_pkg::pcise_cmd_cfg_rd : pcise_pkg::pcise_cmd_cfg_wr;
      next_addr = {cfg_adr[31:2], (bus_select != 2'b00) ? 2'b01 : 2'b00};
      next_be = cfg_ctl[`PCISE_CC_BE_MSB:0];
      next_wdata = cfg_data;
      // idsel is cfg_adr bits 31:11 as written, only for the local bus
      next_idsel = (bus_select == 2'b00) ? cfg_adr[31:`PCISE_CA_DN_LSB] : 21'h00_0000;
    end else if (grant_io) begin
      next_cmd = io_cycle_control[`PCISE_CC_RW] ? pcise_pkg::pcise_cmd_io_rd : pcise_pkg::pcise_cmd_io_wr;
      next_addr = io_adr;
      next_be = io_cycle_control[`PCISE_CC_BE_MSB:0];
      next_wdata = io_data;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state <= pcise_pkg::pcise_idle;
      src <= pcise_pkg::pcise_src_cache;
    end else begin
      case (state)
        pcise_pkg::pcise_idle: begin
          if (grant_cache) begin
            state <= pcise_pkg::pcise_bus;
            src <= pcise_pkg::pcise_src_cache;
          end else if (grant_cfg) begin
            state <= pcise_pkg::pcise_bus;
            src <= pcise_pkg::pcise_src_cfg;
          end else if (grant_io) begin
            state <= pcise_pkg::pcise_bus;
            src <= pcise_pkg::pcise_src_io;
          end
        end
        pcise_pkg::pcise_bus: begin
          if (pci_done_i) begin
            state <= pcise_pkg::pcise_idle;
          end
        end
        default: begin
          state <= pcise_pkg::pcise_idle;
        end
      endcase
    end
  end

  // Request fields are frozen for the whole transaction
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pci_req_o <= 1'b0;
      pci_cmd_o <= 4'h0;
      pci_addr_o <= `PCISE_RST_WORD;
      pci_be_n_o <= 4'hf;
      pci_wdata_o <= `PCISE_RST_WORD;
      pci_idsel_o <= 21'h00_0000;
    end else if (grant_cache || grant_cfg || grant_io) begin
      pci_req_o <= 1'b1;
      pci_cmd_o <= next_cmd;
      pci_addr_o <= next_addr;
      pci_be_n_o <= next_be;
      pci_wdata_o <= next_wdata;
      pci_idsel_o <= next_idsel;
    end else if (finish) begin
      pci_req_o <= 1'b0;
    end
  end

  // Sticky error flags, set wins over write-one clear
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      master_abort_flag <= 1'b0;
      overlap_flag <= 1'b0;
    end else begin
      if (finish && pci_abort_i) begin
        master_abort_flag <= 1'b1;
      end else if (w_status && mmio_wdata_i[`PCISE_ST_MASTER_ABORT]) begin
        master_abort_flag <= 1'b0;
      end
      if (overlap_evt) begin
        overlap_flag <= 1'b1;
      end else if (w_status && mmio_wdata_i[`PCISE_ST_OVERLAP]) begin
        overlap_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      irq_en <= 3'h0;
    end else if (mmio_wr_i && reg_hit(mmio_addr_i, `PCISE_OFS_CONTROL)) begin
      irq_en <= {mmio_wdata_i[`PCISE_CT_IE_OVERLAP], mmio_wdata_i[`PCISE_CT_IE_IO],
                 mmio_wdata_i[`PCISE_CT_IE_CFG]};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cpu_irq_o <= 1'b0;
    end else begin
      cpu_irq_o <= (cfg_done && irq_en[0]) || (io_done && irq_en[1]) || (overlap_flag && irq_en[2]);
    end
  end

  always_comb begin
    rd_word = `PCISE_RST_WORD;
    if (reg_hit(mmio_addr_i, `PCISE_OFS_STATUS)) begin
      rd_word[`PCISE_ST_CFG_BUSY] = cfg_busy;
      rd_word[`PCISE_ST_CFG_DONE] = cfg_done;
      rd_word[`PCISE_ST_IO_BUSY] = io_busy;
      rd_word[`PCISE_ST_IO_DONE] = io_done;
      rd_word[`PCISE_ST_MASTER_ABORT] = master_abort_flag;
      rd_word[`PCISE_ST_OVERLAP] = overlap_flag;
    end else if (reg_hit(mmio_addr_i, `PCISE_OFS_CONTROL)) begin
      rd_word[`PCISE_CT_IE_CFG] = irq_en[0];
      rd_word[`PCISE_CT_IE_IO] = irq_en[1];
      rd_word[`PCISE_CT_IE_OVERLAP] = irq_en[2];
    end else if (reg_hit(mmio_addr_i, `PCISE_OFS_CACHE_ADR) && !mmio_ext_i) begin
      rd_word = {cache_adr, 2'b00};
    end else if (reg_hit(mmio_addr_i, `PCISE_OFS_CACHE_DATA) && !mmio_ext_i) begin
      rd_word = dc_data_o;
    end else if (reg_hit(mmio_addr_i, `PCISE_OFS_CFG_ADR)) begin
      rd_word = cfg_adr;
    end else if (reg_hit(mmio_addr_i, `PCISE_OFS_CFG_DATA)) begin
      rd_word = cfg_data;
    end else if (reg_hit(mmio_addr_i, `PCISE_OFS_CFG_CTL)) begin
      rd_word = {27'h000_0000, cfg_ctl};
    end else if (reg_hit(mmio_addr_i, `PCISE_OFS_IO_ADR)) begin
      rd_word = io_adr;
    end else if (reg_hit(mmio_addr_i, `PCISE_OFS_IO_DATA)) begin
      rd_word = io_data;
    end else if (reg_hit(mmio_addr_i, `PCISE_OFS_IO_CYCLE_CONTROL)) begin
      rd_word = {27'h000_0000, io_cycle_control};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      mmio_rdata_o <= `PCISE_RST_WORD;
    end else begin
      mmio_rdata_o <= mmio_rd_i ? rd_word : `PCISE_RST_WORD;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  a_cfg_launch_busy: assert property (cfg_launch ##1 grant_cfg |=> cfg_busy && pci_req_o) else $error("config launch");
  a_io_launch_busy: assert property (io_launch ##1 grant_io |=> io_busy && pci_req_o) else $error("io launch");
  a_done_ends_busy: assert property ($rose(cfg_done) || $rose(io_done) |-> !cfg_busy && !io_busy) else $error("busy after done");
  a_abort_reads_zero: assert property (finish && src == pcise_pkg::pcise_src_cache && cache_rd && pci_abort_i |=> dc_data_o == 32'h0000_0000 && dc_ready_o) else $error("abort data");
  a_ready_after_done: assert property ($rose(dc_ready_o) |-> $past(finish) && !pci_req_o) else $error("ready");
  a_cache_read_cmd: assert property (grant_cache && dc_read_op_i |=> pci_cmd_o == pcise_pkg::pcise_cmd_mem_rd && pci_be_n_o == 4'h0) else $error("read cmd");
  a_cache_write_data: assert property (grant_cache && !dc_read_op_i |=> pci_cmd_o == pcise_pkg::pcise_cmd_mem_wr && pci_wdata_o == dc_data_o) else $error("write data");
  a_cfg_lanes: assert property (grant_cfg |=> pci_be_n_o == cfg_ctl[3:0] && pci_addr_o[31:2] == cfg_adr[31:2]) else $error("cfg lanes");
  a_overlap_flag: assert property (overlap_evt |=> overlap_flag && $stable(cfg_ctl) && $stable(io_cycle_control)) else $error("overlap");
  a_irq_on_done: assert property ($rose(cfg_done) && irq_en[0] && !(mmio_wr_i && reg_hit(mmio_addr_i, `PCISE_OFS_CONTROL)) |=> cpu_irq_o) else $error("irq");
  a_req_single: assert property (pci_req_o && $past(pci_req_o) |-> $stable(pci_cmd_o) && $stable(pci_addr_o)) else $error("req fields");
  c_cfg_read: cover property (grant_cfg && cfg_ctl[`PCISE_CC_RW] ##[1:50] finish);
  c_io_write: cover property (grant_io && !io_cycle_control[`PCISE_CC_RW] ##[1:50] finish);
  c_cache_abort: cover property (finish && src == pcise_pkg::pcise_src_cache && pci_abort_i);
  c_overlap: cover property (overlap_evt);

endmodule : pcise_engine

// file: bench/pcise_pci_target_model.sv
/*
  Behavioural PCI target answering engine requests after a chosen delay.
  Assumes the engine holds its request until the edge after done.
*/
`timescale 1ns/100ps

module pcise_pci_target_model (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Request and test controls
  input wire logic req_i,
  input wire logic [7:0] delay_i,
  input wire logic abort_i,
  input wire logic [31:0] data_i,
  // Answer
  output logic done_o,
  output logic abort_o,
  output logic [31:0] rdata_o
);
  logic [7:0] count;

  // Data toggles outside done so a stale value never matches
  always @(negedge sys_clk_i) begin
    rdata_o <= ~rdata_o;
    abort_o <= 1'b0;
    done_o <= 1'b0;
    if (reset_i) begin
      count <= 8'h00;
      rdata_o <= 32'h5a5a_a5a5;
    end else if (req_i && !done_o) begin
      count <= count + 8'h01;
      if (count >= delay_i) begin
        done_o <= 1'b1;
        abort_o <= abort_i;
        rdata_o <= data_i;
        count <= 8'h00;
      end
    end
  end
endmodule : pcise_pci_target_model

// file: bench/tb.sv
/*
  Self-checking bench for the PCI initiator engine: cache path, config and
  I/O slots, overlap error. Assumes the target model stands on the PCI side.
*/
`timescale 1ns/100ps
`include "pcise_map.svh"

module tb;
  logic sys_clk_i = 1'b0, reset_i = 1'b1, mmio_wr_i = 1'b0, mmio_rd_i = 1'b0;
  logic mmio_ext_i = 1'b0, dc_adr_wr_i = 1'b0, dc_data_wr_i = 1'b0, dc_read_op_i = 1'b0;
  logic model_abort = 1'b0, dc_ready_o, pci_req_o, pci_done_i, pci_abort_i, cpu_irq_o;
  logic [23:0] mmio_addr_i = 24'h0;
  logic [31:0] mmio_wdata_i = 32'h0, dc_data_i = 32'h0, model_data = 32'h0;
  logic [29:0] dc_adr_i = 30'h0;
  logic [7:0] model_delay = 8'h0;
  logic [31:0] mmio_rdata_o, dc_data_o, pci_addr_o, pci_wdata_o, pci_rdata_i;
  logic [31:0] seen_addr, seen_wdata;
  logic [3:0] pci_cmd_o, pci_be_n_o, seen_cmd, seen_be;
  logic [20:0] pci_idsel_o, seen_idsel;
  logic req_prev = 1'b0;
  int num_errors = 0, compares = 0, req_rises = 0;

  always #25 sys_clk_i = ~sys_clk_i;

  pcise_engine pcise_engine_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .mmio_wr_i(mmio_wr_i), .mmio_rd_i(mmio_rd_i), .mmio_ext_i(mmio_ext_i),
    .mmio_addr_i(mmio_addr_i), .mmio_wdata_i(mmio_wdata_i), .mmio_rdata_o(mmio_rdata_o),
    .dc_adr_wr_i(dc_adr_wr_i), .dc_adr_i(dc_adr_i), .dc_data_wr_i(dc_data_wr_i),
    .dc_data_i(dc_data_i), .dc_read_op_i(dc_read_op_i), .dc_ready_o(dc_ready_o),
    .dc_data_o(dc_data_o), .pci_req_o(pci_req_o), .pci_cmd_o(pci_cmd_o),
    .pci_addr_o(pci_addr_o), .pci_be_n_o(pci_be_n_o), .pci_wdata_o(pci_wdata_o),
    .pci_idsel_o(pci_idsel_o), .pci_done_i(pci_done_i), .pci_abort_i(pci_abort_i),
    .pci_rdata_i(pci_rdata_i), .cpu_irq_o(cpu_irq_o));

  pcise_pci_target_model pcise_pci_target_model_inst (.sys_clk_i(sys_clk_i),
    .reset_i(reset_i), .req_i(pci_req_o), .delay_i(model_delay), .abort_i(model_abort),
    .data_i(model_data), .done_o(pci_done_i), .abort_o(pci_abort_i), .rdata_o(pci_rdata_i));

  always @(posedge sys_clk_i) if (pci_req_o === 1'b1)
    {seen_cmd, seen_addr, seen_be, seen_wdata, seen_idsel} <=
      {pci_cmd_o, pci_addr_o, pci_be_n_o, pci_wdata_o, pci_idsel_o};

  // Counts request starts, one expected per cache request
  always @(posedge sys_clk_i) begin
    req_prev <= pci_req_o;
    if (pci_req_o === 1'b1 && req_prev !== 1'b1) req_rises++;
  end

  task summarize;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task wr(input logic [23:0] a, input logic [31:0] d, input logic ext);
    @(negedge sys_clk_i);
    {mmio_wr_i, mmio_addr_i, mmio_wdata_i, mmio_ext_i} = {1'b1, a, d, ext};
    @(negedge sys_clk_i);
    {mmio_wr_i, mmio_ext_i} = 2'b00;
  endtask : wr

  task rchk(input logic [23:0] a, input logic ext, input logic [31:0] exp);
    @(negedge sys_clk_i);
    {mmio_rd_i, mmio_addr_i, mmio_ext_i} = {1'b1, a, ext};
    @(negedge sys_clk_i);
    {mmio_rd_i, mmio_ext_i} = 2'b00;
    check(mmio_rdata_o, exp);
  endtask : rchk

  task wait_ready(input logic [31:0] mask);
    int n;
    for (n = 0; n < 200 && (mask == 0 ? dc_ready_o !== 1'b1 : 1); n++) begin
      if (mask != 0) begin
        @(negedge sys_clk_i);
        mmio_rd_i = 1'b1;
        mmio_addr_i = `PCISE_OFS_STATUS;
        @(negedge sys_clk_i);
        mmio_rd_i = 1'b0;
        if ((mmio_rdata_o & mask) != 0) break;
      end else @(negedge sys_clk_i);
    end
    check(n < 200, 1'b1);
  endtask : wait_ready

  function logic [3:0] exp_cmd(input logic io, input logic r);
    if (io) return r ? pcise_pkg::pcise_cmd_io_rd : pcise_pkg::pcise_cmd_io_wr;
    return r ? pcise_pkg::pcise_cmd_cfg_rd : pcise_pkg::pcise_cmd_cfg_wr;
  endfunction : exp_cmd

  task cache_op(input logic r, input logic ab);
    logic [29:0] a;
    logic [31:0] d, e;
    int r0;
    a = 30'($urandom);
    r0 = req_rises;
    d = $urandom;
    model_data = $urandom;
    model_abort = ab;
    model_delay = 8'($urandom % 8);
    e = ab ? 32'h0 : (r ? model_data : d);
    @(negedge sys_clk_i);
    {dc_adr_wr_i, dc_adr_i, dc_read_op_i, dc_data_wr_i, dc_data_i} = {1'b1, a, r, !r, d};
    @(negedge sys_clk_i);
    {dc_adr_wr_i, dc_data_wr_i} = 2'b00;
    wait_ready(32'h0);
    {dc_read_op_i, model_abort} = 2'b00;
    check(req_rises - r0, 1);
    check(seen_cmd, r ? 4'h6 : 4'h7);
    check(seen_addr, {a, 2'b00});
    check(seen_be, 4'h0);
    if (!r) check(seen_wdata, d);
    check(dc_data_o, e);
    @(negedge sys_clk_i);
    check(dc_ready_o, 1'b0);
    rchk(`PCISE_OFS_CACHE_DATA, 1'b0, e);
    wr(`PCISE_OFS_CACHE_DATA, ~e, 1'b0);
    rchk(`PCISE_OFS_CACHE_DATA, 1'b0, e);
    rchk(`PCISE_OFS_CACHE_DATA, 1'b1, 32'h0);
    rchk(`PCISE_OFS_STATUS, 1'b0, ab ? 32'h10 : 32'h0);
    wr(`PCISE_OFS_STATUS, 32'h10, 1'b0);
    // local software write of the cache address, done on purpose
    wr(`PCISE_OFS_CACHE_ADR, d, 1'b0);
    rchk(`PCISE_OFS_CACHE_ADR, 1'b0, {d[31:2], 2'b00});
    wr(`PCISE_OFS_CACHE_ADR, ~d, 1'b1);
    rchk(`PCISE_OFS_CACHE_ADR, 1'b0, {d[31:2], 2'b00});
    rchk(`PCISE_OFS_CACHE_ADR, 1'b1, 32'h0);
  endtask : cache_op

  task slot_cycle(input logic io, input logic r, input logic ien, input logic [31:0] a);
    logic [23:0] base;
    logic [31:0] wd;
    logic [3:0] be;
    base = io ? `PCISE_OFS_IO_ADR : `PCISE_OFS_CFG_ADR;
    wd = $urandom;
    be = 4'($urandom);
    model_data = $urandom;
    model_delay = 8'(4 + $urandom % 6);
    // set interrupt enables, set up, launch, await, clear
    wr(`PCISE_OFS_CONTROL, ien ? 32'h4c : 32'h0, 1'b0);
    wr(base, a, 1'b0);
    wr(base + 24'h4, wd, 1'b0);
    wr(base + 24'h8, {27'h0, r, be}, 1'b0);
    rchk(`PCISE_OFS_STATUS, 1'b0, io ? 32'h4 : 32'h1);
    wait_ready(io ? 32'h8 : 32'h2);
    check(seen_cmd, exp_cmd(io, r));
    check(seen_addr, io ? a : {a[31:2], 1'b0, a[1:0] != 2'b00});
    check(seen_idsel, (!io && a[1:0] == 2'b00) ? a[31:11] : 21'h0);
    check(seen_be, be);
    if (!r) check(seen_wdata, wd);
    rchk(base + 24'h4, 1'b0, r ? model_data : wd);
    check(cpu_irq_o, ien);
    rchk(`PCISE_OFS_STATUS, 1'b0, io ? 32'h8 : 32'h2);
    wr(`PCISE_OFS_STATUS, io ? 32'h8 : 32'h2, 1'b0);
    rchk(`PCISE_OFS_STATUS, 1'b0, 32'h0);
    check(cpu_irq_o, 1'b0);
  endtask : slot_cycle

  initial begin
    #(50 * 40000);
    num_errors++;
    summarize;
  end

  initial begin
    logic [31:0] a;
    void'($urandom(50));
    repeat (5) @(negedge sys_clk_i);
    reset_i = 1'b0;
    rchk(`PCISE_OFS_STATUS, 1'b0, 32'h0);
    rchk(`PCISE_OFS_CONTROL, 1'b0, 32'h0);
    rchk(`PCISE_OFS_IO_CYCLE_CONTROL, 1'b0, {27'h0, `PCISE_RST_CTL});
    for (int i = 0; i < 8; i++) cache_op(i[0], i[2:1] == 2'b11);
    for (int i = 0; i < 24; i++) begin
      a = (32'h800 << ($urandom % 21)) | ($urandom & 32'h7fc) | (i[3] ? $urandom % 4 : 0);
      slot_cycle(i[0], i[1], i[2], i[0] ? $urandom : a);
    end
    rchk(24'h10_3040, 1'b0, 32'h0);
    model_delay = 8'd30;
    wr(`PCISE_OFS_CONTROL, 32'h40, 1'b0);
    wr(`PCISE_OFS_CFG_CTL, 32'h10, 1'b0);
    wr(`PCISE_OFS_IO_CYCLE_CONTROL, 32'h10, 1'b0);
    rchk(`PCISE_OFS_STATUS, 1'b0, 32'h101);
    check(cpu_irq_o, 1'b1);
    wait_ready(32'h2);
    check(seen_cmd, 4'ha);
    wr(`PCISE_OFS_STATUS, 32'h102, 1'b0);
    rchk(`PCISE_OFS_STATUS, 1'b0, 32'h0);
    summarize;
  end
endmodule : tb
